// ==== common/mie_pkg.sv ====
// Constants, opcodes and states of the instruction subset executor.
// Assumes a core that fetches, reads operand registers and owns the stack.
// What this block does
// - OR accumulator with file, update zero flag
// - Destination bit 0 accumulator, 1 file
// - Copy file to destination, update zero flag
// - Load eight-bit literal, flags untouched
// - Store accumulator to file, flags untouched
// - Literal return: load, pop, two cycles
// - Rotate left through carry to destination
// - Power-down sets expiry, clears powerdown flag
// - Power-down clears watchdog and prescaler
// - Power-down halts oscillator, enters low power
`default_nettype none

package mie_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FILE_W = 7;
    localparam int PC_W = 13;
    localparam int RADDR_W = 2;

    // ----------------------------------------------------------------
    // Register map, word indexes on the plain register port
    // ----------------------------------------------------------------
    localparam logic [1:0] REG_ACC = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam logic [1:0] REG_DOG = 2'h3;

    // Status fields
    localparam int ST_C_BIT = 0;
    localparam int ST_Z_BIT = 2;
    localparam int ST_PWDN_BIT = 3;
    localparam int ST_EXP_BIT = 4;
    // Control fields
    localparam int CT_IEN_BIT = 0;
    localparam int CT_DOG_EN_BIT = 1;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [7:0] ZERO8 = 8'h00;

    // Watchdog timing
    localparam int PRE_W = 8;
    localparam int DOG_W = 8;
    localparam int PRE_MAX = 127;
    localparam int DOG_MAX = 255;

    // ----------------------------------------------------------------
    // Operations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_OR_ACC = 4'h1,
        OP_COPY = 4'h2,
        OP_LOAD_LIT = 4'h3,
        OP_STORE = 4'h4,
        OP_RET_LIT = 4'h5,
        OP_RET_IRQ = 4'h6,
        OP_ROT_LEFT = 4'h7,
        OP_POWER_DOWN = 4'h8
    } mie_op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SECOND = 2'b01,
        ST_SLEEP = 2'b10
    } mie_state_t;
endpackage

`default_nettype wire

// ==== src/mie_count.sv ====
// Free counter with synchronous clear and wrap pulse.
// Assumes enable and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module mie_count #(
    parameter int W = 8,
    parameter int MAX = 255
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    output logic [W-1:0] count,
    output logic wrap
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] cnt;
    } mie_cnt_t;

    mie_cnt_t s;
    mie_cnt_t next_s;

    initial begin
        if (W < 1 || MAX < 1 || MAX > (2 ** W) - 1) begin
            $error("mie_count: MAX does not fit W");
        end
    end

    assign count = s.cnt;
    assign wrap = en && (s.cnt == W'(MAX));

    always_comb begin
        next_s = s;
        if (clr) begin
            next_s.cnt = '0;
        end else if (wrap) begin
            next_s.cnt = '0;
        end else if (en) begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // mie_count

`default_nettype wire

// ==== src/mie_exec.sv ====
// Executes the instruction subset and holds accumulator, flags and pc.
// Assumes the core supplies the operand register value with each op and
// holds instr_valid low while ready is low.
`timescale 1ns/100ps
`default_nettype none

module mie_exec
    import mie_pkg::*;
#(
    parameter int PRE_LIMIT = PRE_MAX,
    parameter int DOG_LIMIT = DOG_MAX
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [3:0] op_code,
    input wire logic [FILE_W-1:0] op_file,
    input wire logic op_dest,
    input wire logic [DATA_W-1:0] op_lit,
    input wire logic [DATA_W-1:0] op_fval,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic wake_pin,
    input wire logic [RADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic ready,
    output logic done,
    output logic [DATA_W-1:0] acc,
    output logic zero_flag,
    output logic carry_flag,
    output logic expiry_flag,
    output logic powerdown_flag,
    output logic global_interrupt_enable,
    output logic [PC_W-1:0] pc,
    output logic file_we,
    output logic [FILE_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic osc_run,
    output logic [DOG_W-1:0] watchdog_counter
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        mie_state_t st;
        logic rdy;
        logic done;
        logic [DATA_W-1:0] acc;
        logic zf;
        logic cf;
        logic tof;
        logic pdf;
        logic ien;
        logic dog_en;
        logic [PC_W-1:0] pc;
        logic fwe;
        logic [FILE_W-1:0] fwaddr;
        logic [DATA_W-1:0] fwdata;
        logic [DATA_W-1:0] rdata;
        logic osc;
        logic wake_m;
        logic wake_s;
    } mie_exec_t;

    mie_exec_t s;
    mie_exec_t next_s;
    logic go;
    logic dog_clr;
    logic dog_wrap;
    logic pre_wrap;
    logic [PRE_W-1:0] pre_count;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] stat_word;
    mie_op_t op;

    initial begin
        if (PRE_LIMIT < 1 || DOG_LIMIT < 1) begin
            $error("mie_exec: watchdog limits must be positive");
        end
    end

    assign op = mie_op_t'(op_code);
    assign go = (s.st == ST_RUN) && instr_valid;
    // Sleep wipes both stages of the watchdog
    assign dog_clr = go && (op == OP_POWER_DOWN);

    // ----------------------------------------------------------------
    // Watchdog prescaler and counter
    // ----------------------------------------------------------------
    // Watchdog keeps running in sleep; a time-out does not end it, only the wake pin does.
    mie_count #(.W(PRE_W), .MAX(PRE_LIMIT)) u_pre (
        .mclk(mclk),
        .rst_n(rst_n),
        .clr(dog_clr),
        .en(s.dog_en),
        .count(pre_count),
        .wrap(pre_wrap)
    );

    mie_count #(.W(DOG_W), .MAX(DOG_LIMIT)) u_dog (
        .mclk(mclk),
        .rst_n(rst_n),
        .clr(dog_clr),
        .en(pre_wrap),
        .count(watchdog_counter),
        .wrap(dog_wrap)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        stat_word = ZERO8;
        stat_word[ST_C_BIT] = s.cf;
        stat_word[ST_Z_BIT] = s.zf;
        stat_word[ST_PWDN_BIT] = s.pdf;
        stat_word[ST_EXP_BIT] = s.tof;
        res = ZERO8;
        next_s = s;
        next_s.done = 1'b0;
        next_s.fwe = 1'b0;
        next_s.wake_m = wake_pin;
        next_s.wake_s = s.wake_m;
        // A time-out clears the expiry flag; a power-down in the same cycle wins
        if (dog_wrap) begin
            next_s.tof = 1'b0;
        end

        // Register port; an instruction in the same cycle wins
        if (reg_rd) begin
            unique case (reg_addr)
                REG_ACC: next_s.rdata = s.acc;
                REG_STATUS: next_s.rdata = stat_word;
                REG_CTRL: begin
                    next_s.rdata = ZERO8;
                    next_s.rdata[CT_IEN_BIT] = s.ien;
                    next_s.rdata[CT_DOG_EN_BIT] = s.dog_en;
                end
                REG_DOG: next_s.rdata = watchdog_counter;
            endcase
        end
        if (reg_wr) begin
            unique case (reg_addr)
                REG_ACC: next_s.acc = reg_wdata;
                REG_STATUS: begin
                    next_s.cf = reg_wdata[ST_C_BIT];
                    next_s.zf = reg_wdata[ST_Z_BIT];
                end
                REG_CTRL: begin
                    next_s.ien = reg_wdata[CT_IEN_BIT];
                    next_s.dog_en = reg_wdata[CT_DOG_EN_BIT];
                end
                REG_DOG: ;
            endcase
        end

        unique case (s.st)
            ST_RUN: begin
                if (instr_valid) begin
                    next_s.done = 1'b1;
                    next_s.pc = s.pc + PC_STEP;
                    unique case (op)
                        OP_OR_ACC: begin
                            res = s.acc | op_fval;
                            next_s.zf = (res == ZERO8);
                        end
                        OP_COPY: begin
                            res = op_fval;
                            next_s.zf = (res == ZERO8);
                        end
                        OP_LOAD_LIT: begin
                            next_s.acc = op_lit;
                        end
                        OP_STORE: begin
                            next_s.fwe = 1'b1;
                            next_s.fwaddr = op_file;
                            next_s.fwdata = s.acc;
                        end
                        OP_RET_LIT: begin
                            // Second cycle is the refetch after the pop
                            next_s.acc = op_lit;
                            next_s.pc = stack_top;
                            next_s.st = ST_SECOND;
                            next_s.rdy = 1'b0;
                        end
                        OP_RET_IRQ: begin
                            next_s.pc = stack_top;
                            next_s.ien = 1'b1;
                            next_s.st = ST_SECOND;
                            next_s.rdy = 1'b0;
                        end
                        OP_ROT_LEFT: begin
                            res = {op_fval[DATA_W-2:0], s.cf};
                            next_s.cf = op_fval[DATA_W-1];
                        end
                        OP_POWER_DOWN: begin
                            next_s.tof = 1'b1;
                            next_s.pdf = 1'b0;
                            next_s.st = ST_SLEEP;
                            next_s.rdy = 1'b0;
                            next_s.osc = 1'b0;
                        end
                        default: ;
                    endcase
                    // Destination select for ops that carry one
                    if (op == OP_OR_ACC || op == OP_COPY || op == OP_ROT_LEFT) begin
                        if (op_dest) begin
                            next_s.fwe = 1'b1;
                            next_s.fwaddr = op_file;
                            next_s.fwdata = res;
                        end else begin
                            next_s.acc = res;
                        end
                    end
                end
            end
            ST_SECOND: begin
                next_s.st = ST_RUN;
                next_s.rdy = 1'b1;
            end
            ST_SLEEP: begin
                // Only the synchronised wake pin restarts the clock
                if (s.wake_s) begin
                    next_s.st = ST_RUN;
                    next_s.rdy = 1'b1;
                    next_s.osc = 1'b1;
                end
            end
            default: begin
                next_s.st = ST_RUN;
                next_s.rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s.st <= ST_RUN;
            s.rdy <= 1'b1;
            s.done <= 1'b0;
            s.acc <= ACC_RST;
            s.zf <= 1'b0;
            s.cf <= 1'b0;
            s.tof <= 1'b1;
            s.pdf <= 1'b1;
            s.ien <= 1'b0;
            s.dog_en <= 1'b0;
            s.pc <= PC_RST;
            s.fwe <= 1'b0;
            s.fwaddr <= '0;
            s.fwdata <= ZERO8;
            s.rdata <= ZERO8;
            s.osc <= 1'b1;
            s.wake_m <= 1'b0;
            s.wake_s <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign ready = s.rdy;
    assign done = s.done;
    assign acc = s.acc;
    assign zero_flag = s.zf;
    assign carry_flag = s.cf;
    assign expiry_flag = s.tof;
    assign powerdown_flag = s.pdf;
    assign global_interrupt_enable = s.ien;
    assign pc = s.pc;
    assign file_we = s.fwe;
    assign file_waddr = s.fwaddr;
    assign file_wdata = s.fwdata;
    assign osc_run = s.osc;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_or_acc_result: assert property (
        go && op == OP_OR_ACC && !op_dest |=>
            acc == ($past(acc) | $past(op_fval)) && zero_flag == (acc == ZERO8))
        else $error("or into accumulator wrong");

    chk_dest_file_write: assert property (
        go && op == OP_OR_ACC && op_dest && !reg_wr |=>
            file_we && file_waddr == $past(op_file) && acc == $past(acc)
            && file_wdata == ($past(acc) | $past(op_fval)))
        else $error("destination file write wrong");

    chk_copy_zero: assert property (
        go && op == OP_COPY |=> zero_flag == ($past(op_fval) == ZERO8))
        else $error("copy zero flag wrong");

    chk_literal_load: assert property (
        go && op == OP_LOAD_LIT && !reg_wr |=>
            acc == $past(op_lit) && $stable(zero_flag) && $stable(carry_flag))
        else $error("literal load wrong");

    chk_store_word: assert property (
        go && op == OP_STORE && !reg_wr |=>
            file_we && file_wdata == $past(acc) && $stable(zero_flag))
        else $error("store to file wrong");

    chk_return_literal: assert property (
        go && op == OP_RET_LIT |=>
            !ready && acc == $past(op_lit) && pc == $past(stack_top) ##1 ready)
        else $error("literal return wrong");

    chk_rotate_carry: assert property (
        go && op == OP_ROT_LEFT && !op_dest |=>
            acc == {$past(op_fval[DATA_W-2:0]), $past(carry_flag)}
            && carry_flag == $past(op_fval[DATA_W-1]))
        else $error("rotate through carry wrong");

    chk_sleep_flags: assert property (
        go && op == OP_POWER_DOWN |=> expiry_flag && !powerdown_flag)
        else $error("power-down flags wrong");

    chk_dog_clear: assert property (
        go && op == OP_POWER_DOWN |=> watchdog_counter == '0 && pre_count == '0)
        else $error("watchdog not cleared");

    chk_sleep_halt: assert property (
        go && op == OP_POWER_DOWN |=> !osc_run && !ready)
        else $error("oscillator not halted");

    chk_sleep_holds: assert property (
        s.st == ST_SLEEP && !s.wake_s |=> !osc_run && !ready)
        else $error("sleep left without wake");

    chk_irq_return: assert property (
        go && op == OP_RET_IRQ && !reg_wr |=>
            global_interrupt_enable && pc == $past(stack_top) && $stable(zero_flag))
        else $error("interrupt return wrong");

    chk_idle_quiet: assert property (
        go && op == OP_IDLE && !reg_wr |=>
            pc == PC_W'($past(pc) + PC_STEP) && $stable(acc) && !file_we)
        else $error("idle op changed state");
endmodule // mie_exec

`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the instruction subset executor.
// Assumes mie_exec as declared in the design and the mie_pkg constants.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import mie_pkg::*;

    // ----------------------------------------------------------------
    // Signals and expected state
    // ----------------------------------------------------------------
    logic mclk, rst_n, instr_valid, op_dest, wake_pin, reg_wr, reg_rd;
    logic [3:0] op_code;
    logic [FILE_W-1:0] op_file, file_waddr;
    logic [DATA_W-1:0] op_lit, op_fval, reg_wdata, reg_rdata, acc, file_wdata;
    logic [PC_W-1:0] stack_top, pc;
    logic [RADDR_W-1:0] reg_addr;
    logic ready, done, zero_flag, carry_flag, expiry_flag, powerdown_flag;
    logic global_interrupt_enable, file_we, osc_run;
    logic [DOG_W-1:0] watchdog_counter;
    logic [7:0] e_acc, rv;
    logic e_z, e_c, e_ien;
    logic [12:0] e_pc;
    logic [31:0] lfsr, r1, r2;
    int fails, tests_run, cycles;

    // Short limits keep the watchdog busy within a short run
    mie_exec #(.PRE_LIMIT(3), .DOG_LIMIT(3)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .op_code(op_code),
        .op_file(op_file), .op_dest(op_dest), .op_lit(op_lit), .op_fval(op_fval),
        .stack_top(stack_top), .wake_pin(wake_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ready(ready), .done(done), .acc(acc), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .expiry_flag(expiry_flag),
        .powerdown_flag(powerdown_flag), .global_interrupt_enable(global_interrupt_enable),
        .pc(pc), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .osc_run(osc_run), .watchdog_counter(watchdog_counter)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // One instruction: results are due one cycle after it is taken
    task automatic exec(input logic [3:0] op, input logic [6:0] f, input logic d,
                        input logic [7:0] l, input logic [7:0] v, input logic [12:0] st);
        logic [7:0] res;
        logic alu;
        logic we;
        logic [7:0] wd;
        @(posedge mclk);
        instr_valid <= 1'b1;
        op_code <= op;
        op_file <= f;
        op_dest <= d;
        op_lit <= l;
        op_fval <= v;
        stack_top <= st;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        res = 8'h00;
        alu = 1'b0;
        we = 1'b0;
        wd = 8'h00;
        e_pc = e_pc + 13'h0001;
        case (op)
            4'h1: begin
                res = e_acc | v;
                e_z = (res == 8'h00);
                alu = 1'b1;
            end
            4'h2: begin
                res = v;
                e_z = (res == 8'h00);
                alu = 1'b1;
            end
            4'h3: e_acc = l;
            4'h4: begin
                we = 1'b1;
                wd = e_acc;
            end
            4'h5: begin
                e_acc = l;
                e_pc = st;
            end
            4'h6: begin
                e_pc = st;
                e_ien = 1'b1;
            end
            4'h7: begin
                res = {v[6:0], e_c};
                e_c = v[7];
                alu = 1'b1;
            end
            default: ;
        endcase
        if (alu && d) begin
            we = 1'b1;
            wd = res;
        end else if (alu) begin
            e_acc = res;
        end
        chk(done, 1'b1);
        chk(acc, e_acc);
        chk(file_we, we);
        if (we) begin
            chk(file_waddr, f);
            chk(file_wdata, wd);
        end
        chk(zero_flag, e_z);
        chk(carry_flag, e_c);
        chk(pc, e_pc);
        chk(global_interrupt_enable, e_ien);
        // Returns take two cycles, so the port must refuse for one
        if (op == 4'h5 || op == 4'h6)
            chk(ready, 1'b0);
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, instr_valid, op_dest, wake_pin, reg_wr, reg_rd} = 6'h00;
        {op_code, op_file, op_lit, op_fval, stack_top, reg_addr, reg_wdata} = '0;
        {fails, tests_run, cycles} = '0;
        {e_acc, e_z, e_c, e_ien, e_pc} = '0;
        lfsr = 32'he3315dd4;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk({ready, osc_run, expiry_flag, powerdown_flag, acc, pc}, {4'hf, 8'h00, 13'h0000});
        $display("test reset done");

        // Boundary operands and each opcode but power-down by hand
        exec(4'h3, 7'h00, 1'b0, 8'hff, 8'h00, 13'h0000);
        exec(4'h1, 7'h7f, 1'b1, 8'h00, 8'h00, 13'h0000);
        exec(4'h3, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0000);
        exec(4'h1, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0000);
        exec(4'h2, 7'h05, 1'b1, 8'h00, 8'h80, 13'h0000);
        exec(4'h2, 7'h05, 1'b1, 8'h00, 8'h00, 13'h0000);
        wr(2'h1, 8'h01);
        e_c = 1'b1;
        e_z = 1'b0;
        exec(4'h7, 7'h03, 1'b0, 8'h00, 8'h80, 13'h0000);
        exec(4'h7, 7'h03, 1'b1, 8'h00, 8'h00, 13'h0000);
        exec(4'h4, 7'h7f, 1'b0, 8'h00, 8'h00, 13'h0000);
        exec(4'h5, 7'h00, 1'b0, 8'ha5, 8'h00, 13'h1abc);
        exec(4'h6, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0fff);
        exec(4'h0, 7'h11, 1'b1, 8'h5a, 8'h5a, 13'h0000);
        $display("test corners done");

        // An instruction offered while a return holds ready low is dropped
        @(posedge mclk);
        instr_valid <= 1'b1;
        op_code <= 4'h5;
        op_lit <= 8'h3c;
        stack_top <= 13'h0123;
        @(posedge mclk);
        op_code <= 4'h3;
        op_lit <= 8'hc3;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk({done, acc, pc}, {1'b0, 8'h3c, 13'h0123});
        e_acc = 8'h3c;
        e_pc = 13'h0123;
        $display("test refusal done");

        // Random mix of everything but power-down
        repeat (300) begin
            lfsr = lfsr_next(lfsr);
            r1 = lfsr;
            lfsr = lfsr_next(lfsr);
            r2 = lfsr;
            exec((r1[3:0] == 4'h8) ? 4'h0 : r1[3:0], r1[10:4], r1[11], r1[19:12],
                 r2[7:0], r2[20:8]);
        end
        rd(2'h0, rv);
        chk(rv, e_acc);
        $display("test random done");

        // Power-down with the watchdog running, then wake
        wr(2'h2, 8'h02);
        e_ien = 1'b0;
        // Limits of 3 and 3: a time-out after 16 cycles, count 2 after 26
        repeat (26) @(posedge mclk);
        #1;
        chk(expiry_flag, 1'b0);
        chk(watchdog_counter, 8'h02);
        exec(4'h8, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0000);
        chk({expiry_flag, powerdown_flag}, 2'b10);
        chk(watchdog_counter, 8'h00);
        chk({osc_run, ready}, 2'b00);
        rd(2'h1, rv);
        chk(rv & 8'h18, 8'h10);
        @(posedge mclk);
        wake_pin <= 1'b1;
        // Two synchroniser stages, then the state change: awake three edges on
        repeat (2) @(posedge mclk);
        #1;
        chk({osc_run, ready}, 2'b00);
        @(posedge mclk);
        wake_pin <= 1'b0;
        #1;
        chk({osc_run, ready}, 2'b11);
        $display("test power-down done");
        results();
    end
endmodule // testbench

`default_nettype wire
